// file: src/pci_master_burst_write.sv
// Burst memory write master: local word intake, FIFO, PCI data phases
// Assumes pins synchronous to clock; the bench leaves outputs and enables unresolved
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps

// --------------------------------------------------------------
// Word FIFO
// --------------------------------------------------------------
module word_fifo #(
	parameter int W = 65,
	parameter int D = 8
)(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [$clog2(D+1)-1:0] level
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [$clog2(D+1)-1:0] count_r;
	logic push;
	logic pop;

	assign in_ready = (count_r != D[$clog2(D+1)-1:0]);
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_r];
	assign level = count_r;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_r] <= in_data;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			wr_r <= '0;
			rd_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wr_r <= (wr_r == AW'(D - 1)) ? '0 : wr_r + 1'b1;
			if (pop)
				rd_r <= (rd_r == AW'(D - 1)) ? '0 : rd_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule

// --------------------------------------------------------------
// Top
// --------------------------------------------------------------
module pci_master_burst_write (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pci_mw_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic local_master_ready_n,
	input wire logic local_final_phase_n,
	input wire logic local_narrow_request_n,
	input wire logic [pci_mw_pkg::DATA_W-1:0] l_adi,
	output logic local_master_ack_n,
	output logic local_word_transfer_n,
	output logic local_low_data_ack_n,
	output logic local_high_data_ack_n,
	output logic [pci_mw_pkg::TSR_W-1:0] master_transaction_status,
	input wire logic trdy_n,
	input wire logic devsel_n,
	input wire logic ack64_n,
	output logic frame_n_out,
	output logic frame_n_oe,
	output logic req64_n_out,
	output logic req64_n_oe,
	output logic irdy_n_out,
	output logic irdy_n_oe,
	output logic [pci_mw_pkg::DATA_W-1:0] ad_out,
	output logic ad_oe,
	output logic [pci_mw_pkg::BE_W-1:0] cben_out,
	output logic cben_oe
);
	import pci_mw_pkg::*;

	bus_state_e state_r;
	logic [31:0] ctrl_r;
	logic [31:0] addr_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic ack_n_r;
	logic xfer_n_r;
	logic high_ack_n_r;
	logic open_r;
	logic wide_r;
	logic [TSR_W-1:0] tsr_r;
	logic frame_n_r;
	logic frame_oe_r;
	logic req64_n_r;
	logic req64_oe_r;
	logic irdy_n_r;
	logic irdy_oe_r;
	logic [DATA_W-1:0] ad_r;
	logic ad_oe_r;
	logic [BE_W-1:0] cben_r;
	logic hold_valid_r;
	logic hold_last_r;
	logic devsel_ok_r;
	logic wr_en;
	logic start_go;
	logic last_take;
	logic open_nxt;
	logic ack_nxt;
	logic xfer_nxt;
	logic complete;
	logic load;
	logic hold_valid_nxt;
	logic hold_last_nxt;
	logic irdy_nxt;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [FIFO_W-1:0] fifo_out;
	logic [LEVEL_W-1:0] fifo_level;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign local_master_ack_n = ack_n_r;
	assign local_word_transfer_n = xfer_n_r;
	assign local_low_data_ack_n = xfer_n_r;
	assign local_high_data_ack_n = high_ack_n_r;
	assign master_transaction_status = tsr_r;
	assign frame_n_out = frame_n_r;
	assign frame_n_oe = frame_oe_r;
	assign req64_n_out = req64_n_r;
	assign req64_n_oe = req64_oe_r;
	assign irdy_n_out = irdy_n_r;
	assign irdy_n_oe = irdy_oe_r;
	assign ad_out = ad_r;
	assign ad_oe = ad_oe_r;
	assign cben_out = cben_r;
	assign cben_oe = ad_oe_r;

	// --------------------------------------------------------------
	// APB slave, one wait-free access phase
	// --------------------------------------------------------------
	assign wr_en = psel & penable & pwrite & pready_r;
	assign start_go = wr_en & (paddr == OFF_CTRL) & pwdata[CTRL_START] & (state_r == ST_IDLE);

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			pready_r <= psel & ~penable;
			pslverr_r <= psel & ~penable & (paddr != OFF_CTRL) & (paddr != OFF_ADDR)
				& (paddr != OFF_STATUS);
			prdata_r <= 32'h0000_0000;
			if (psel && !penable && !pwrite)
			begin
				case (paddr)
					OFF_CTRL: prdata_r <= ctrl_r;
					OFF_ADDR: prdata_r <= addr_r;
					OFF_STATUS: prdata_r <= {15'h0000, state_r != ST_IDLE, 6'h00, tsr_r};
					default: prdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			ctrl_r <= CTRL_RESET;
			addr_r <= ADDR_RESET;
		end
		else if (wr_en)
		begin
			if (paddr == OFF_CTRL)
				ctrl_r <= {16'h0000, pwdata[15:1], 1'b0};
			if (paddr == OFF_ADDR)
				addr_r <= pwdata;
		end
	end

	// --------------------------------------------------------------
	// Local side intake
	// --------------------------------------------------------------
	always_comb
	begin
		last_take = ~xfer_n_r & ~local_final_phase_n;
		open_nxt = open_r;
		if (start_go)
			open_nxt = 1'b1;
		else if (last_take)
			open_nxt = 1'b0;
		ack_nxt = open_nxt & fifo_in_ready & (fifo_level < FILL_LIMIT);
		xfer_nxt = ack_nxt & ~local_master_ready_n;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			open_r <= 1'b0;
			ack_n_r <= 1'b1;
			xfer_n_r <= 1'b1;
			high_ack_n_r <= 1'b1;
			wide_r <= 1'b0;
		end
		else
		begin
			open_r <= open_nxt;
			ack_n_r <= ~ack_nxt;
			xfer_n_r <= ~xfer_nxt;
			high_ack_n_r <= ~(xfer_nxt & (start_go ? local_narrow_request_n : wide_r));
			if (start_go)
				wide_r <= local_narrow_request_n;
		end
	end

	word_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) fifo_i (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(~xfer_n_r),
		.in_data({~local_final_phase_n, l_adi}),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_ready(load),
		.out_data(fifo_out),
		.level(fifo_level)
	);

	// --------------------------------------------------------------
	// PCI data phases
	// --------------------------------------------------------------
	always_comb
	begin
		complete = (state_r == ST_DATA) & ~irdy_n_r & ~trdy_n;
		load = fifo_out_valid & (~hold_valid_r | complete)
			& ((state_r == ST_ADDR) | (state_r == ST_DATA));
		hold_valid_nxt = load | (hold_valid_r & ~complete);
		hold_last_nxt = load ? fifo_out[DATA_W] : hold_last_r;
		irdy_nxt = (state_r == ST_DATA) & hold_valid_nxt & (devsel_ok_r | ~devsel_n);
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			hold_valid_r <= 1'b0;
			hold_last_r <= 1'b0;
			devsel_ok_r <= 1'b0;
			frame_n_r <= 1'b1;
			frame_oe_r <= 1'b0;
			req64_n_r <= 1'b1;
			req64_oe_r <= 1'b0;
			irdy_n_r <= 1'b1;
			irdy_oe_r <= 1'b0;
			ad_r <= '0;
			ad_oe_r <= 1'b0;
			cben_r <= '0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					irdy_oe_r <= 1'b0;
					ad_oe_r <= 1'b0;
					hold_valid_r <= 1'b0;
					hold_last_r <= 1'b0;
					devsel_ok_r <= 1'b0;
					if (start_go)
					begin
						state_r <= ST_ADDR;
						frame_n_r <= 1'b0;
						frame_oe_r <= 1'b1;
						req64_n_r <= ~local_narrow_request_n;
						req64_oe_r <= local_narrow_request_n;
						irdy_n_r <= 1'b1;
						irdy_oe_r <= 1'b1;
						ad_r <= {32'h0000_0000, addr_r};
						ad_oe_r <= 1'b1;
						cben_r <= {4'h0, ctrl_r[CTRL_CMD_LSB +: 4]};
					end
				end
				ST_ADDR, ST_DATA:
				begin
					state_r <= ST_DATA;
					hold_valid_r <= hold_valid_nxt;
					hold_last_r <= hold_last_nxt;
					if (state_r == ST_DATA && !devsel_n)
						devsel_ok_r <= 1'b1;
					cben_r <= ctrl_r[CTRL_BE_LSB +: BE_W] | {{4{~wide_r}}, 4'h0};
					if (load)
						ad_r <= wide_r ? fifo_out[DATA_W-1:0]
							: {32'h0000_0000, fifo_out[HALF_W-1:0]};
					irdy_n_r <= ~irdy_nxt;
					if (irdy_nxt && hold_last_nxt)
					begin
						frame_n_r <= 1'b1;
						req64_n_r <= 1'b1;
					end
					if (complete && hold_last_r)
					begin
						state_r <= ST_END;
						irdy_n_r <= 1'b1;
						frame_oe_r <= 1'b0;
						req64_oe_r <= 1'b0;
						ad_oe_r <= 1'b0;
					end
				end
				ST_END:
				begin
					state_r <= ST_IDLE;
					irdy_oe_r <= 1'b0;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// --------------------------------------------------------------
	// Transaction status
	// --------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			tsr_r <= '0;
		else
		begin
			tsr_r[TSR_ADDR] <= start_go;
			tsr_r[TSR_PHASE_OK] <= complete;
			if (state_r == ST_ADDR)
				tsr_r[TSR_DATA] <= 1'b1;
			else if (state_r == ST_END)
				tsr_r[TSR_DATA] <= 1'b0;
			if (start_go)
				tsr_r[TSR_WIDE] <= 1'b0;
			else if (state_r == ST_DATA && wide_r && !devsel_n && !ack64_n)
				tsr_r[TSR_WIDE] <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence last_word_taken;
		!xfer_n_r && !local_final_phase_n;
	endsequence
	sequence final_phase_done;
		complete && hold_last_r;
	endsequence

	xfer_cause_a: assert property (
		!xfer_n_r |-> !ack_n_r && !$past(local_master_ready_n) && !local_low_data_ack_n)
		else $error("strobe without ready and acknowledge");
	push_room_a: assert property (
		!xfer_n_r |-> fifo_in_ready)
		else $error("word taken with no room");
	word_move_a: assert property (
		complete && !hold_last_r && fifo_level == 4'h0 |=> irdy_n_r || $past(load))
		else $error("completed phase word not retired");
	phase_flag_a: assert property (
		complete |=> tsr_r[TSR_PHASE_OK] ##0 $past(!irdy_n_r && !trdy_n))
		else $error("phase flag not set after completion");
	wide_flag_a: assert property (
		$rose(tsr_r[TSR_WIDE]) |-> wide_r && $past(!ack64_n && !devsel_n))
		else $error("wide flag without ack64");
	last_frame_a: assert property (
		!irdy_n_r && frame_n_r && frame_oe_r |-> hold_last_r)
		else $error("frame released before last phase");
	local_close_a: assert property (
		last_word_taken |=> ack_n_r && xfer_n_r [*2])
		else $error("acknowledge stays after last word");
	end_float_a: assert property (
		final_phase_done |=> irdy_n_r && irdy_oe_r && !frame_oe_r && !req64_oe_r ##1 !irdy_oe_r)
		else $error("bus not released after final phase");
	mode_end_a: assert property (
		final_phase_done |=> ##1 !tsr_r[TSR_DATA])
		else $error("data mode flag stays after end");
	narrow_req_a: assert property (
		!wide_r && state_r != ST_IDLE |-> !req64_oe_r && high_ack_n_r)
		else $error("req64 asserted for narrow request");
	ready_drop_a: assert property (
		local_master_ready_n |=> xfer_n_r)
		else $error("strobe after ready dropped");
	pci_wait_a: assert property (
		state_r == ST_DATA && !hold_valid_r && !fifo_out_valid |=> irdy_n_r)
		else $error("irdy asserted with no word");
	devsel_wait_a: assert property (
		$fell(irdy_n_r) |-> devsel_ok_r || $past(!devsel_n))
		else $error("irdy before devsel");
endmodule

// file: src/pci_mw_pkg.sv
// Constants, field layout and state type of the burst write master
// Assumes a single 25 MHz clock and a zero-wait APB register port
package pci_mw_pkg;
	// --------------------------------------------------------------
	// Widths and depths
	// --------------------------------------------------------------
	localparam int DATA_W = 64;
	localparam int HALF_W = 32;
	localparam int BE_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W = DATA_W + 1;
	localparam int LEVEL_W = 4;
	localparam logic [LEVEL_W-1:0] FILL_LIMIT = 4'h6;
	localparam int TSR_W = 10;
	// --------------------------------------------------------------
	// Status bit positions
	// --------------------------------------------------------------
	localparam int TSR_ADDR = 2;
	localparam int TSR_DATA = 3;
	localparam int TSR_PHASE_OK = 8;
	localparam int TSR_WIDE = 9;
	// --------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------
	localparam int APB_AW = 12;
	localparam logic [APB_AW-1:0] OFF_CTRL = 12'h000;
	localparam logic [APB_AW-1:0] OFF_ADDR = 12'h004;
	localparam logic [APB_AW-1:0] OFF_STATUS = 12'h008;
	localparam int CTRL_START = 0;
	localparam int CTRL_CMD_LSB = 4;
	localparam int CTRL_BE_LSB = 8;
	localparam int STAT_BUSY = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0070;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
	// --------------------------------------------------------------
	// Bus sequencer states
	// --------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_END} bus_state_e;
endpackage

// file: testbench/pci_master_burst_write_tb.sv
// Self-checking bench for the burst write master
// Assumes the target model beside the design and the APB port
`timescale 1ns/1ps
module pci_master_burst_write_tb;
	import pci_mw_pkg::*;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic local_master_ready_n, local_final_phase_n, local_narrow_request_n;
	logic [DATA_W-1:0] l_adi, ad_out;
	logic local_master_ack_n, local_word_transfer_n, local_low_data_ack_n;
	logic local_high_data_ack_n;
	logic [TSR_W-1:0] master_transaction_status;
	logic trdy_n, devsel_n, ack64_n, frame_n_out, frame_n_oe, req64_n_out, req64_n_oe;
	logic irdy_n_out, irdy_n_oe, ad_oe, cben_oe;
	logic [BE_W-1:0] cben_out;
	logic wide_ok, r_prev, pc, fin, lastw, narrow;
	logic [3:0] lat;
	int miscompares = 0;
	int n_compared = 0;

	pci_master_burst_write DUT (.*);
	pci_target_model tgt (.*);

	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// --------------------------------------------------------------
	// Tasks
	// --------------------------------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic run(input int n, input logic nar, input logic ok, input logic [3:0] l,
		input int gap);
		logic [63:0] w [$];
		logic [63:0] m;
		logic stl;
		int idx, st, k;
		tgt.got.delete();
		narrow = nar;
		local_narrow_request_n <= !nar;
		wide_ok <= ok;
		lat <= l;
		for (k = 0; k < n; k++)
			w.push_back({32'hA5A5_0000 | k, 32'h5A5A_0000 | k});
		idx = 0;
		st = 0;
		l_adi <= w[0];
		local_final_phase_n <= (n != 1);
		local_master_ready_n <= 1'b0;
		apb(1'b1, OFF_CTRL, 32'h0000_0071);
		for (k = 0; k < 400 && idx < n; k++)
		begin
			@(posedge clock);
			if (local_word_transfer_n === 1'b0)
				idx++;
			stl = idx >= gap && st < 3;
			st += stl;
			local_master_ready_n <= idx >= n || stl;
			if (idx < n)
				l_adi <= w[idx];
			local_final_phase_n <= idx != n - 1;
		end
		for (k = 0; k < 60; k++)
		begin
			apb(1'b0, OFF_STATUS, 32'h0000_0000);
			if (rd[STAT_BUSY] === 1'b0)
				break;
		end
		apb(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(rd[TSR_DATA], 1'b0);
		chk(rd[TSR_WIDE], !nar && ok);
		chk(tgt.got.size(), n);
		// Upper half is lost when a wide burst meets a narrow target
		m = (!nar && !ok) ? 64'h0000_0000_FFFF_FFFF : 64'hFFFF_FFFF_FFFF_FFFF;
		for (k = 0; k < n && k < tgt.got.size(); k++)
			chk(tgt.got[k] & m, (nar ? {32'h0000_0000, w[k][31:0]} : w[k]) & m);
	endtask

	always @(posedge clock)
	begin
		if (rst_n === 1'b1)
		begin
			if (!r_prev && !local_master_ack_n)
				chk(local_word_transfer_n, 1'b0);
			if (r_prev)
				chk(local_word_transfer_n, 1'b1);
			chk(local_low_data_ack_n, local_word_transfer_n);
			chk(master_transaction_status[TSR_PHASE_OK], pc);
			if (lastw)
				chk({local_master_ack_n, local_word_transfer_n}, 2'b11);
			if (fin)
				chk({irdy_n_out, frame_n_oe, req64_n_oe}, 3'b100);
			if (frame_n_oe && frame_n_out)
				chk(irdy_n_out, 1'b0);
			if (irdy_n_oe && !irdy_n_out)
			begin
				chk(devsel_n, 1'b0);
				chk(cben_out, {{4{narrow}}, 4'h0});
			end
			if (narrow && frame_n_oe)
				chk({req64_n_oe, local_high_data_ack_n}, 2'b01);
			if (master_transaction_status[TSR_ADDR])
			begin
				chk({cben_oe, ad_oe, cben_out}, {2'b11, 8'h07});
				chk(ad_out, 64'h0000_0000_1000_0040);
			end
		end
		r_prev <= local_master_ready_n || !rst_n;
		pc <= rst_n && !irdy_n_out && irdy_n_oe && !trdy_n;
		fin <= rst_n && frame_n_out && frame_n_oe && !irdy_n_out && !trdy_n;
		lastw <= rst_n && !local_word_transfer_n && !local_final_phase_n;
	end

	// --------------------------------------------------------------
	// Tests
	// --------------------------------------------------------------
	initial
	begin
		{rst_n, psel, penable, pwrite, narrow, wide_ok} = 6'b000000;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		{local_master_ready_n, local_final_phase_n, local_narrow_request_n} = 3'b111;
		l_adi = 64'h0000_0000_0000_0000;
		lat = 4'h0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		chk({local_master_ack_n, local_word_transfer_n, irdy_n_oe, frame_n_oe, ad_oe}, 5'b11000);
		chk(master_transaction_status, 10'h000);
		apb(1'b0, OFF_CTRL, 32'h0000_0000);
		chk(rd, CTRL_RESET);
		apb(1'b0, OFF_ADDR, 32'h0000_0000);
		chk(rd, ADDR_RESET);
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk({err, rd}, {1'b1, 32'h0000_0000});
		apb(1'b1, OFF_ADDR, 32'h1000_0040);
		apb(1'b0, OFF_ADDR, 32'h0000_0000);
		chk(rd, 32'h1000_0040);
		run(4, 1'b0, 1'b1, 4'h0, 99);
		run(3, 1'b1, 1'b1, 4'h0, 99);
		run(5, 1'b0, 1'b0, 4'h2, 2);
		run(1, 1'b1, 1'b1, 4'h1, 99);
		wrap_up();
	end

	initial
	begin
		#(40 * 30000);
		miscompares++;
		wrap_up();
	end
endmodule

// file: testbench/pci_target_model.sv
// Behavioural PCI target that claims, accepts and ends write bursts
// Assumes it sees the master's registered pin values and enables
`timescale 1ns/1ps
module pci_target_model (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic frame_n_out,
	input wire logic frame_n_oe,
	input wire logic irdy_n_out,
	input wire logic irdy_n_oe,
	input wire logic req64_n_out,
	input wire logic req64_n_oe,
	input wire logic [63:0] ad_out,
	input wire logic wide_ok,
	input wire logic [3:0] lat,
	output logic trdy_n,
	output logic devsel_n,
	output logic ack64_n
);
	logic [63:0] got [$];
	logic act;
	logic [3:0] cnt;
	logic done;

	assign done = !irdy_n_out && irdy_n_oe && !trdy_n;

	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			act <= 1'b0;
			cnt <= 4'h0;
			{devsel_n, trdy_n, ack64_n} <= 3'b111;
		end
		else if (!act && frame_n_oe && !frame_n_out)
		begin
			// Fast decode claim, optional initial wait states
			act <= 1'b1;
			devsel_n <= 1'b0;
			ack64_n <= !(wide_ok && req64_n_oe && !req64_n_out);
			trdy_n <= (lat != 4'h0);
			cnt <= lat;
		end
		else if (act)
		begin
			cnt <= (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
			trdy_n <= (cnt > 4'h1);
			if (done)
				got.push_back(ad_out);
			if (done && frame_n_out)
			begin
				// Released lines go high through their pull-ups
				act <= 1'b0;
				{devsel_n, trdy_n, ack64_n} <= 3'b111;
			end
		end
	end
endmodule
